// ===== lkirq_defs.svh
// Register offsets, field positions, reset values and limits for the link 2 interrupt gating
`ifndef LKIRQ_DEFS_SVH
`define LKIRQ_DEFS_SVH

// ****************************************************************
// Register offsets
// ****************************************************************
`define LKIRQ_OFF_ENABLE 8'h00
`define LKIRQ_OFF_EVT_STATUS 8'h01
`define LKIRQ_OFF_OVS_STATUS 8'h02
`define LKIRQ_OFF_OVS_ENABLE 8'h03
`define LKIRQ_OFF_LEN_LOW 8'h04
`define LKIRQ_OFF_LEN_HIGH 8'h05
`define LKIRQ_OFF_PENDING 8'h06

// ****************************************************************
// Field positions
// ****************************************************************
`define LKIRQ_BIT_TX_BEGIN 6
`define LKIRQ_BIT_RX_BEGIN 5
`define LKIRQ_BIT_TX_FINISH 4
`define LKIRQ_BIT_RX_FINISH 3
`define LKIRQ_BIT_FCS_FAIL 2
`define LKIRQ_BIT_ABORT 1
`define LKIRQ_BIT_IDLE 0
`define LKIRQ_BIT_MSG_TYPE 7
`define LKIRQ_BIT_OVERSIZE 0
`define LKIRQ_PEND_OVS_BIT 7
`define LKIRQ_EVT_COUNT 7

// ****************************************************************
// Reset values and limits
// ****************************************************************
`define LKIRQ_RST_ENABLE 7'h00
`define LKIRQ_RST_FLAGS 7'h00
`define LKIRQ_RST_DATA 8'h00
`define LKIRQ_MAX_MSG_BYTES 276
`define LKIRQ_LEN_WIDTH 9

`endif

// ===== lkirq_pkg.sv
// Types shared by the link 2 interrupt gating modules
package lkirq_pkg;

  // ****************************************************************
  // Message length monitor states
  // ****************************************************************
  typedef enum logic [2:0]
  {
    LKIRQ_IDLE = 3'b001,
    LKIRQ_COUNT = 3'b010,
    LKIRQ_OVER = 3'b100
  } lkirq_len_state_type;

  typedef logic [7:0] lkirq_byte_type;

endpackage : lkirq_pkg

// ===== lkirq_flag_bank.sv
// Sticky event flags with clear-on-read and write-one-to-clear
`timescale 1ns/1ps
module lkirq_flag_bank
#(
  parameter int WIDTH = 7
)
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Events
  input wire logic [WIDTH-1:0] set_pulse,
  // Software clears
  input wire logic read_clear,
  input wire logic write_clear,
  input wire logic [WIDTH-1:0] clear_mask,
  // Flags
  output logic [WIDTH-1:0] flags
);

  logic [WIDTH-1:0] flags_next;
  logic [WIDTH-1:0] clear_bits;

  initial
  begin
    if (WIDTH < 1 || WIDTH > 8)
      $error("lkirq_flag_bank: WIDTH must be 1 to 8");
  end

  // An event in the clearing cycle survives: set is applied after clear
  always_comb
  begin
    clear_bits = '0;
    if (read_clear)
      clear_bits = '1;
    else if (write_clear)
      clear_bits = clear_mask;
    flags_next = (flags & ~clear_bits) | set_pulse;
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      flags <= '0;
    else
      flags <= flags_next;
  end

endmodule : lkirq_flag_bank

// ===== lkirq_size_monitor.sv
// Counts received message bytes and flags a message longer than the limit
`timescale 1ns/1ps
`include "lkirq_defs.svh"
module lkirq_size_monitor
#(
  parameter int MAX_LEN = `LKIRQ_MAX_MSG_BYTES,
  parameter int LEN_W = `LKIRQ_LEN_WIDTH
)
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Receive framing
  input wire logic msg_begin,
  input wire logic msg_end,
  input wire logic byte_valid,
  // Results
  output logic oversize_pulse,
  output logic [LEN_W-1:0] byte_count
);

  lkirq_pkg::lkirq_len_state_type state_reg;
  lkirq_pkg::lkirq_len_state_type state_next;
  logic at_limit;

  initial
  begin
    if (MAX_LEN < 1 || MAX_LEN >= (2 ** LEN_W) - 1)
      $error("lkirq_size_monitor: MAX_LEN does not fit LEN_W");
  end

  assign at_limit = (byte_count == LEN_W'(MAX_LEN));

  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      lkirq_pkg::LKIRQ_IDLE:
        if (msg_begin)
          state_next = lkirq_pkg::LKIRQ_COUNT;
      lkirq_pkg::LKIRQ_COUNT:
        if (msg_end)
          state_next = lkirq_pkg::LKIRQ_IDLE;
        else if (byte_valid && at_limit)
          state_next = lkirq_pkg::LKIRQ_OVER;
      lkirq_pkg::LKIRQ_OVER:
        if (msg_end)
          state_next = lkirq_pkg::LKIRQ_IDLE;
        else if (msg_begin)
          state_next = lkirq_pkg::LKIRQ_COUNT;
      default:
        state_next = lkirq_pkg::LKIRQ_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      state_reg <= lkirq_pkg::LKIRQ_IDLE;
    else
      state_reg <= state_next;
  end

  // Count is kept after the message ends so software can read the length
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      byte_count <= '0;
    else if (msg_begin)
      byte_count <= '0;
    else if (byte_valid && state_reg != lkirq_pkg::LKIRQ_IDLE && !(&byte_count))
      byte_count <= byte_count + LEN_W'(1);
  end

  // One pulse per message, on the byte that passes the limit
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      oversize_pulse <= 1'b0;
    else
      oversize_pulse <= (state_reg == lkirq_pkg::LKIRQ_COUNT) && byte_valid && at_limit
        && !msg_end && !msg_begin;
  end

endmodule : lkirq_size_monitor

// ===== lkirq_link2_irq_gating.sv
// Interrupt enables, sticky event status and oversize message status for data link 2
`timescale 1ns/1ps
`include "lkirq_defs.svh"
module lkirq_link2_irq_gating
#(
  parameter int MAX_MSG_BYTES = `LKIRQ_MAX_MSG_BYTES,
  parameter int LEN_W = `LKIRQ_LEN_WIDTH
)
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wr_data,
  input wire logic reg_wr_strobe,
  input wire logic reg_rd_strobe,
  output logic [7:0] reg_rd_data,
  // Transmit engine events
  input wire logic tx_begin_evt,
  input wire logic tx_finish_evt,
  // Receive engine events
  input wire logic rx_begin_evt,
  input wire logic rx_finish_evt,
  input wire logic frame_check_fail_evt,
  input wire logic abort_seen_evt,
  input wire logic idle_flag_evt,
  // Receive data and message type
  input wire logic rx_byte_valid,
  input wire logic rx_msg_type,
  // Interrupt request
  output logic irq
);

  // ****************************************************************
  // Elaboration checks
  // ****************************************************************
  initial
  begin
    if (LEN_W < 9 || LEN_W > 16)
      $error("lkirq_link2_irq_gating: LEN_W must be 9 to 16");
    if (MAX_MSG_BYTES < 1)
      $error("lkirq_link2_irq_gating: MAX_MSG_BYTES must be positive");
    if (MAX_MSG_BYTES >= (2 ** LEN_W) - 1)
      $error("lkirq_link2_irq_gating: MAX_MSG_BYTES does not fit LEN_W");
  end

  // ****************************************************************
  // Decode helpers
  // ****************************************************************
  function automatic logic addr_is(input logic [7:0] addr, input logic [7:0] offset);
    addr_is = (addr == offset);
  endfunction : addr_is

  function automatic logic [7:0] pad_flags(input logic [6:0] bits);
    pad_flags = {1'b0, bits};
  endfunction : pad_flags

  // ****************************************************************
  // Signals
  // ****************************************************************
  // Register state
  logic [6:0] enable_reg;
  logic [6:0] enable_next;
  logic ovs_enable_reg;
  logic ovs_enable_next;

  // Flag banks and length monitor
  logic [6:0] evt_set;
  logic [6:0] evt_flags;
  logic [0:0] ovs_flags;
  logic ovs_pulse;
  logic [LEN_W-1:0] msg_len;
  logic msg_end;

  // Decoded strobes
  logic wr_enable;
  logic wr_evt_status;
  logic wr_ovs_status;
  logic wr_ovs_enable;
  logic rd_evt_status;
  logic rd_ovs_status;

  // Gating
  logic [6:0] evt_pending;
  logic ovs_pending;

  // Read path
  logic [15:0] len_wide;
  logic [7:0] rd_value;
  logic [7:0] reg_rd_data_reg;
  logic [7:0] reg_rd_data_next;

  // Interrupt request
  logic irq_reg;
  logic irq_next;

  // ****************************************************************
  // Write strobes
  // ****************************************************************
  assign wr_enable = reg_wr_strobe && addr_is(reg_addr, `LKIRQ_OFF_ENABLE);
  assign wr_evt_status = reg_wr_strobe && addr_is(reg_addr, `LKIRQ_OFF_EVT_STATUS);
  assign wr_ovs_status = reg_wr_strobe && addr_is(reg_addr, `LKIRQ_OFF_OVS_STATUS);
  assign wr_ovs_enable = reg_wr_strobe && addr_is(reg_addr, `LKIRQ_OFF_OVS_ENABLE);

  // ****************************************************************
  // Read strobes
  // ****************************************************************
  // Only a strobed cycle clears; an address left standing never does
  assign rd_evt_status = reg_rd_strobe && addr_is(reg_addr, `LKIRQ_OFF_EVT_STATUS);
  assign rd_ovs_status = reg_rd_strobe && addr_is(reg_addr, `LKIRQ_OFF_OVS_STATUS);

  // ****************************************************************
  // Interrupt enable register
  // ****************************************************************
  // Bit 7 is reserved: it is not stored and reads as zero
  always_comb
  begin
    enable_next = enable_reg;
    if (wr_enable)
      enable_next = reg_wr_data[6:0];
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      enable_reg <= `LKIRQ_RST_ENABLE;
    end
    else
    begin
      enable_reg <= enable_next;
    end
  end

  // ****************************************************************
  // Oversize enable register
  // ****************************************************************
  always_comb
  begin
    ovs_enable_next = ovs_enable_reg;
    if (wr_ovs_enable)
      ovs_enable_next = reg_wr_data[`LKIRQ_BIT_OVERSIZE];
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      ovs_enable_reg <= 1'b0;
    end
    else
    begin
      ovs_enable_reg <= ovs_enable_next;
    end
  end

  // ****************************************************************
  // Event set vector
  // ****************************************************************
  always_comb
  begin
    evt_set = '0;
    evt_set[`LKIRQ_BIT_TX_BEGIN] = tx_begin_evt;
    evt_set[`LKIRQ_BIT_RX_BEGIN] = rx_begin_evt;
    evt_set[`LKIRQ_BIT_TX_FINISH] = tx_finish_evt;
    evt_set[`LKIRQ_BIT_RX_FINISH] = rx_finish_evt;
    evt_set[`LKIRQ_BIT_FCS_FAIL] = frame_check_fail_evt;
    evt_set[`LKIRQ_BIT_ABORT] = abort_seen_evt;
    evt_set[`LKIRQ_BIT_IDLE] = idle_flag_evt;
  end

  // ****************************************************************
  // Event flag bank
  // ****************************************************************
  // Flags clear on read of the status word and also on write of ones
  lkirq_flag_bank
  #(
    .WIDTH(`LKIRQ_EVT_COUNT)
  )
  u_evt_flags
  (
    .clk_sys(clk_sys),
    .rst(rst),
    .set_pulse(evt_set),
    .read_clear(rd_evt_status),
    .write_clear(wr_evt_status),
    .clear_mask(reg_wr_data[6:0]),
    .flags(evt_flags)
  );

  // ****************************************************************
  // Message length monitor
  // ****************************************************************
  // An abort also ends the message, so a truncated frame cannot leave the count open
  assign msg_end = rx_finish_evt || abort_seen_evt;

  lkirq_size_monitor
  #(
    .MAX_LEN(MAX_MSG_BYTES),
    .LEN_W(LEN_W)
  )
  u_size_monitor
  (
    .clk_sys(clk_sys),
    .rst(rst),
    .msg_begin(rx_begin_evt),
    .msg_end(msg_end),
    .byte_valid(rx_byte_valid),
    .oversize_pulse(ovs_pulse),
    .byte_count(msg_len)
  );

  // ****************************************************************
  // Oversize flag
  // ****************************************************************
  // Cleared by a read or by writing a one; a new oversize wins over either
  lkirq_flag_bank
  #(
    .WIDTH(1)
  )
  u_ovs_flag
  (
    .clk_sys(clk_sys),
    .rst(rst),
    .set_pulse(ovs_pulse),
    .read_clear(rd_ovs_status),
    .write_clear(wr_ovs_status),
    .clear_mask(reg_wr_data[`LKIRQ_BIT_OVERSIZE:`LKIRQ_BIT_OVERSIZE]),
    .flags(ovs_flags)
  );

  // ****************************************************************
  // Gating
  // ****************************************************************
  // Masking acts on the request only; software still sees every latched flag
  assign evt_pending = evt_flags & enable_reg;
  assign ovs_pending = ovs_flags[0] && ovs_enable_reg;

  // ****************************************************************
  // Read multiplexer
  // ****************************************************************
  assign len_wide = 16'(msg_len);

  always_comb
  begin
    rd_value = `LKIRQ_RST_DATA;
    case (reg_addr)
      `LKIRQ_OFF_ENABLE:
      begin
        rd_value = pad_flags(enable_reg);
      end
      `LKIRQ_OFF_EVT_STATUS:
      begin
        rd_value = pad_flags(evt_flags);
        rd_value[`LKIRQ_BIT_MSG_TYPE] = rx_msg_type;
      end
      `LKIRQ_OFF_OVS_STATUS:
      begin
        rd_value = {7'h00, ovs_flags[0]};
      end
      `LKIRQ_OFF_OVS_ENABLE:
      begin
        rd_value = {7'h00, ovs_enable_reg};
      end
      `LKIRQ_OFF_LEN_LOW:
      begin
        rd_value = len_wide[7:0];
      end
      `LKIRQ_OFF_LEN_HIGH:
      begin
        rd_value = len_wide[15:8];
      end
      `LKIRQ_OFF_PENDING:
      begin
        rd_value = pad_flags(evt_pending);
        rd_value[`LKIRQ_PEND_OVS_BIT] = ovs_pending;
      end
      default:
      begin
        rd_value = `LKIRQ_RST_DATA;
      end
    endcase
  end

  // ****************************************************************
  // Read data register
  // ****************************************************************
  // Data stand only in the cycle after the read strobe; zero otherwise
  always_comb
  begin
    reg_rd_data_next = `LKIRQ_RST_DATA;
    if (reg_rd_strobe)
      reg_rd_data_next = rd_value;
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      reg_rd_data_reg <= `LKIRQ_RST_DATA;
    end
    else
    begin
      reg_rd_data_reg <= reg_rd_data_next;
    end
  end

  assign reg_rd_data = reg_rd_data_reg;

  // ****************************************************************
  // Interrupt request
  // ****************************************************************
  // Registered so the pin is glitch free; costs one cycle of latency
  always_comb
  begin
    irq_next = (|evt_pending) || ovs_pending;
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      irq_reg <= 1'b0;
    end
    else
    begin
      irq_reg <= irq_next;
    end
  end

  assign irq = irq_reg;

endmodule : lkirq_link2_irq_gating

// ===== lkirq_gating_assertions.sv
// Port checker for the link 2 interrupt gating block
`timescale 1ns/1ps
`include "lkirq_defs.svh"
module lkirq_gating_assertions
#(
  parameter int MAX_MSG_BYTES = `LKIRQ_MAX_MSG_BYTES,
  parameter int LEN_W = `LKIRQ_LEN_WIDTH
)
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wr_data,
  input wire logic reg_wr_strobe,
  input wire logic reg_rd_strobe,
  input wire logic [7:0] reg_rd_data,
  // Events
  input wire logic tx_begin_evt,
  input wire logic tx_finish_evt,
  input wire logic rx_begin_evt,
  input wire logic rx_finish_evt,
  input wire logic frame_check_fail_evt,
  input wire logic abort_seen_evt,
  input wire logic idle_flag_evt,
  // Receive data and interrupt
  input wire logic rx_byte_valid,
  input wire logic rx_msg_type,
  input wire logic irq
);
  // ****************
  // Helper logic
  // ****************
  logic [6:0] evt;
  logic any_evt;
  logic [6:0] en_q;
  logic ovs_en_q;
  logic rd_evt;
  logic rd_ovs;
  logic acc_en;
  assign evt = {tx_begin_evt, rx_begin_evt, tx_finish_evt, rx_finish_evt,
    frame_check_fail_evt, abort_seen_evt, idle_flag_evt};
  assign any_evt = |evt;
  assign rd_evt = reg_rd_strobe && (reg_addr == `LKIRQ_OFF_EVT_STATUS);
  assign rd_ovs = reg_rd_strobe && (reg_addr == `LKIRQ_OFF_OVS_STATUS);
  assign acc_en = reg_addr == `LKIRQ_OFF_ENABLE;

  // Shadow of the enables so gating can be judged without the bodies
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      en_q <= 7'h00;
      ovs_en_q <= 1'b0;
    end
    else if (reg_wr_strobe && acc_en)
      en_q <= reg_wr_data[6:0];
    else if (reg_wr_strobe && (reg_addr == `LKIRQ_OFF_OVS_ENABLE))
      ovs_en_q <= reg_wr_data[0];
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  // ****************
  // Sequences
  // ****************
  sequence s_en_write_read;
    (reg_wr_strobe && acc_en) ##1 !reg_wr_strobe ##1 (reg_rd_strobe && acc_en);
  endsequence
  sequence s_evt_reread;
    (rd_evt && (evt == 7'h00)) ##1 (evt == 7'h00) ##1 rd_evt;
  endsequence
  sequence s_ovs_reread;
    (rd_ovs && !rx_byte_valid && !$past(rx_byte_valid)) ##1 !rx_byte_valid ##1 rd_ovs;
  endsequence

  // ****************
  // Assertions
  // ****************
  a_rd_data_idle: assert property (!$past(reg_rd_strobe) |-> (reg_rd_data == 8'h00))
    else $error("read data not zero outside read cycle");
  a_enable_readback: assert property (s_en_write_read |=>
    (reg_rd_data == {1'b0, $past(reg_wr_data[6:0], 3)}))
    else $error("enable register read back differs");
  a_evt_raises_irq: assert property
    (((evt & en_q) != 7'h00) && !reg_wr_strobe |-> ##2 irq)
    else $error("enabled event gave no interrupt");
  a_irq_has_cause: assert property ($rose(irq) |->
    $past(any_evt, 2) || $past(reg_wr_strobe, 2) || $past(rx_byte_valid, 3))
    else $error("interrupt rose without cause");
  a_irq_all_masked: assert property
    (($past(en_q) == 7'h00) && !$past(ovs_en_q) |-> !irq)
    else $error("interrupt while all enables clear");
  a_evt_clear_read: assert property (s_evt_reread |=>
    (reg_rd_data[6:0] == 7'h00))
    else $error("event status not cleared by read");
  a_ovs_clear_read: assert property (s_ovs_reread |=> (reg_rd_data == 8'h00))
    else $error("oversize status not cleared by read");
  a_ovs_upper_zero: assert property (rd_ovs |=> (reg_rd_data[7:1] == 7'h00))
    else $error("oversize status upper bits set");
  a_msg_type_live: assert property (rd_evt |=> (reg_rd_data[7] == $past(rx_msg_type)))
    else $error("message type bit wrong");
endmodule : lkirq_gating_assertions

bind lkirq_link2_irq_gating lkirq_gating_assertions
  #(.MAX_MSG_BYTES(MAX_MSG_BYTES), .LEN_W(LEN_W)) u_gating_chk
(
  .clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr), .reg_wr_data(reg_wr_data),
  .reg_wr_strobe(reg_wr_strobe), .reg_rd_strobe(reg_rd_strobe), .reg_rd_data(reg_rd_data),
  .tx_begin_evt(tx_begin_evt), .tx_finish_evt(tx_finish_evt), .rx_begin_evt(rx_begin_evt),
  .rx_finish_evt(rx_finish_evt), .frame_check_fail_evt(frame_check_fail_evt),
  .abort_seen_evt(abort_seen_evt), .idle_flag_evt(idle_flag_evt),
  .rx_byte_valid(rx_byte_valid), .rx_msg_type(rx_msg_type), .irq(irq)
);

// ===== tb_top.sv
// Self-checking testbench for the link 2 interrupt gating block
`timescale 1ns/1ps
`include "lkirq_defs.svh"
module tb_top;
  // Short message limit keeps the oversize run brief
  localparam int MAX_LEN = 5;
  logic clk_sys;
  logic rst;
  logic [7:0] reg_addr;
  logic [7:0] reg_wr_data;
  logic reg_wr_strobe;
  logic reg_rd_strobe;
  logic [7:0] reg_rd_data;
  logic [6:0] evt;
  logic rx_byte_valid;
  logic rx_msg_type;
  logic irq;
  int err_total;
  int samples_checked;

  lkirq_link2_irq_gating #(.MAX_MSG_BYTES(MAX_LEN)) DUT
  (
    .clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr), .reg_wr_data(reg_wr_data),
    .reg_wr_strobe(reg_wr_strobe), .reg_rd_strobe(reg_rd_strobe), .reg_rd_data(reg_rd_data),
    .tx_begin_evt(evt[6]), .rx_begin_evt(evt[5]), .tx_finish_evt(evt[4]),
    .rx_finish_evt(evt[3]), .frame_check_fail_evt(evt[2]), .abort_seen_evt(evt[1]),
    .idle_flag_evt(evt[0]), .rx_byte_valid(rx_byte_valid), .rx_msg_type(rx_msg_type),
    .irq(irq)
  );

  // ****************
  // Tasks
  // ****************
  task automatic tally_and_finish;
    if ((err_total == 0) && (samples_checked > 0))
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : tally_and_finish

  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      $display("wrong value %s expected %h seen %h", what, exp, got);
      err_total++;
    end
  endtask : check

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wr_data <= d;
    reg_wr_strobe <= 1'b1;
    @(posedge clk_sys);
    reg_wr_strobe <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd_strobe <= 1'b1;
    @(posedge clk_sys);
    reg_rd_strobe <= 1'b0;
    @(negedge clk_sys);
    check("reg_rd_data", exp, reg_rd_data);
  endtask : rd

  task automatic pulse(input logic [6:0] m);
    @(posedge clk_sys);
    evt <= m;
    @(posedge clk_sys);
    evt <= 7'h00;
  endtask : pulse

  task automatic bytes(input int n);
    repeat (n)
    begin
      @(posedge clk_sys);
      rx_byte_valid <= 1'b1;
    end
    @(posedge clk_sys);
    rx_byte_valid <= 1'b0;
  endtask : bytes

  // Three edges cover the flag and the registered interrupt
  task automatic irq_is(input logic exp);
    repeat (3) @(posedge clk_sys);
    @(negedge clk_sys);
    check("irq", {7'h00, exp}, {7'h00, irq});
  endtask : irq_is

  initial
  begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end

  initial
  begin
    repeat (5000) @(posedge clk_sys);
    err_total++;
    tally_and_finish();
  end

  // ****************
  // Tests
  // ****************
  initial
  begin
    err_total = 0;
    samples_checked = 0;
    rst = 1'b1;
    reg_addr = 8'h00;
    reg_wr_data = 8'h00;
    reg_wr_strobe = 1'b0;
    reg_rd_strobe = 1'b0;
    evt = 7'h00;
    rx_byte_valid = 1'b0;
    rx_msg_type = 1'b0;
    repeat (10) @(posedge clk_sys);
    rst <= 1'b0;
    rd(`LKIRQ_OFF_ENABLE, 8'h00);
    rd(`LKIRQ_OFF_EVT_STATUS, 8'h00);
    rd(`LKIRQ_OFF_OVS_STATUS, 8'h00);
    rd(`LKIRQ_OFF_OVS_ENABLE, 8'h00);
    wr(`LKIRQ_OFF_ENABLE, 8'hFF);
    rd(`LKIRQ_OFF_ENABLE, 8'h7F);
    wr(8'h20, 8'hFF);
    rd(8'h20, 8'h00);
    rd(`LKIRQ_OFF_ENABLE, 8'h7F);
    // Each event alone, first masked with all others enabled, then enabled
    for (int i = 0; i < 7; i++)
    begin
      wr(`LKIRQ_OFF_ENABLE, ~(8'h01 << i) & 8'h7F);
      pulse(7'h01 << i);
      irq_is(1'b0);
      rd(`LKIRQ_OFF_EVT_STATUS, 8'h01 << i);
      wr(`LKIRQ_OFF_ENABLE, 8'h01 << i);
      pulse(7'h01 << i);
      irq_is(1'b1);
      rd(`LKIRQ_OFF_PENDING, 8'h01 << i);
      rd(`LKIRQ_OFF_EVT_STATUS, 8'h01 << i);
      irq_is(1'b0);
    end
    // Flag latched while masked raises the interrupt once enabled
    wr(`LKIRQ_OFF_ENABLE, 8'h00);
    pulse(7'h0C);
    wr(`LKIRQ_OFF_EVT_STATUS, 8'h04);
    wr(`LKIRQ_OFF_ENABLE, 8'h08);
    irq_is(1'b1);
    @(posedge clk_sys);
    rx_msg_type <= 1'b1;
    rd(`LKIRQ_OFF_EVT_STATUS, 8'h88);
    rd(`LKIRQ_OFF_EVT_STATUS, 8'h80);
    irq_is(1'b0);
    wr(`LKIRQ_OFF_ENABLE, 8'h00);
    // Message at the limit, then one byte over it
    pulse(7'h20);
    bytes(MAX_LEN);
    pulse(7'h08);
    rd(`LKIRQ_OFF_OVS_STATUS, 8'h00);
    rd(`LKIRQ_OFF_LEN_LOW, 8'(MAX_LEN));
    rd(`LKIRQ_OFF_LEN_HIGH, 8'h00);
    pulse(7'h20);
    bytes(MAX_LEN + 1);
    irq_is(1'b0);
    wr(`LKIRQ_OFF_OVS_ENABLE, 8'h01);
    irq_is(1'b1);
    rd(`LKIRQ_OFF_PENDING, 8'h80);
    rd(`LKIRQ_OFF_OVS_STATUS, 8'h01);
    rd(`LKIRQ_OFF_OVS_STATUS, 8'h00);
    irq_is(1'b0);
    rd(`LKIRQ_OFF_OVS_ENABLE, 8'h01);
    // An abort ends the message, so a later stray byte is not counted
    pulse(7'h20);
    bytes(MAX_LEN);
    pulse(7'h02);
    bytes(1);
    rd(`LKIRQ_OFF_OVS_STATUS, 8'h00);
    rd(`LKIRQ_OFF_LEN_LOW, 8'(MAX_LEN));
    // Oversize flag cleared by writing a one
    pulse(7'h20);
    bytes(MAX_LEN + 1);
    wr(`LKIRQ_OFF_OVS_STATUS, 8'h01);
    rd(`LKIRQ_OFF_OVS_STATUS, 8'h00);
    tally_and_finish();
  end
endmodule : tb_top
